// ### rtl/dmf_consts.svh
// Offsets, field positions and codes of the data map fault and maintenance block
// Function
// [R1] The readback holder is read-only; software writes never change it.
// [R2] Entry port read copies the entry to the holder; holder read returns it.
// [R3] A data-stream fault loads the fault status register unless it is locked.
// [R4] After capture both capture registers stay locked until the fault address is read.
// [R5] Status bits change only when unlocked and an error or miss occurs.
// [R6] Reset leaves both capture registers unlocked.
// [R7] Handler software unlocks capture registers when entered above a data map miss.
// [R8] Store flag is set for a faulting write, clear otherwise.
// [R9] Access violation flag is set when the reference violated access.
// [R10] Fault-on-read flag set for a read whose entry had fault-on-read.
// [R11] Fault-on-store flag set for a write whose entry had fault-on-write.
// [R12] Status also holds source register and opcode fields; all read-only.
// [R13] Fault or miss latches the virtual address into the fault address register.
// [R14] Any write to clear-all invalidates every small and large entry.
// [R15] Clear-all also returns the replacement pointers to their initial state.
// [R16] Non-global clear invalidates entries whose all-space-match bit is zero.
// [R17] Single clear invalidates entries mapping the supplied virtual address.
// [R18] Any write to the flush register invalidates the whole instruction cache.
// [R19] Non-global flush invalidates instruction cache blocks with all-space-match clear.
// [R20] New entries go to the replacement-pointer slot of the selected page size.
// [R21] Each entry port read or write advances the selected entry pointer.
// [R22] Reading the fault address register releases the lock on both registers.
// [R23] Command write data is ignored except the single-clear address.
`ifndef DMF_CONSTS_SVH
`define DMF_CONSTS_SVH

// Register byte offsets
`define DMF_OFF_SIZE_CTL 8'h00
`define DMF_OFF_STAGE 8'h04
`define DMF_OFF_TAG 8'h08
`define DMF_OFF_PORT 8'h0C
`define DMF_OFF_HOLD_LO 8'h10
`define DMF_OFF_HOLD_HI 8'h14
`define DMF_OFF_FSTAT 8'h18
`define DMF_OFF_FADDR_LO 8'h1C
`define DMF_OFF_FADDR_HI 8'h20
`define DMF_OFF_UNLOCK 8'h24
`define DMF_OFF_CLR_ALL 8'h28
`define DMF_OFF_CLR_NG 8'h2C
`define DMF_OFF_CLR_ONE 8'h30
`define DMF_OFF_IC_ALL 8'h34
`define DMF_OFF_IC_NG 8'h38
`define DMF_OFF_INFO 8'h3C

// Fault status fields
`define DMF_FS_WR 0
`define DMF_FS_ACV 1
`define DMF_FS_FOR 2
`define DMF_FS_FOW 3
`define DMF_FS_RA 4
`define DMF_FS_OP 9

// Entry fields and large page tag bits ignored
`define DMF_PTE_ASM 4
`define DMF_LARGE_IGN 9

// Info register fields
`define DMF_INFO_LOCK 0
`define DMF_INFO_SPTR 8
`define DMF_INFO_LPTR 16

// Bus response codes
`define DMF_RESP_OK 2'h0
`define DMF_RESP_ERR 2'h2

`endif

// ### rtl/dmf_map_array.sv
// Entry storage and invalidation for one page size of the data map buffer
`timescale 1ns/1ps
`default_nettype none
`include "dmf_consts.svh"
module dmf_map_array #(
    parameter int unsigned N = 32,
    parameter int unsigned IGN = 0,
    parameter int unsigned IW = $clog2(N)
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Entry write and read
    input wire logic wr_i,
    input wire logic [IW-1:0] idx_i,
    input wire logic [31:0] tag_i,
    input wire logic [63:0] pte_i,
    output logic [63:0] pte_o,
    // Invalidation commands
    input wire logic inv_all_i,
    input wire logic inv_ng_i,
    input wire logic inv_one_i,
    input wire logic [31:0] va_tag_i
);
    logic [63:0] pte_a [N];

    // One slot per entry; an invalidate beats a write to the same slot
    for (genvar e = 0; e < N; e++) begin : g_ent
        logic v_q, v_d, hit;
        logic [63:0] p_q, p_d;
        logic [31:0] t_q, t_d;
        // Large pages ignore the low tag bits inside their span
        assign hit = (t_q >> IGN) == (va_tag_i >> IGN);
        assign pte_a[e] = p_q;
        always_comb begin
            v_d = v_q;
            p_d = p_q;
            t_d = t_q;
            if (wr_i && idx_i == IW'(e)) begin
                v_d = 1'b1;
                p_d = pte_i;
                t_d = tag_i;
            end
            if (inv_all_i) begin
                v_d = 1'b0; // R14
            end else if (inv_ng_i && !p_q[`DMF_PTE_ASM]) begin
                v_d = 1'b0; // R16
            end else if (inv_one_i && v_q && hit) begin
                v_d = 1'b0; // R17
            end
        end
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                v_q <= 1'b0;
                p_q <= 64'h0;
                t_q <= 32'h0;
            end else if (ce_i) begin
                v_q <= v_d;
                p_q <= p_d;
                t_q <= t_d;
            end
        end
    end

    // Readback of the slot under the pointer
    assign pte_o = pte_a[idx_i];
endmodule
`default_nettype wire

// ### rtl/dmf_pkg.sv
// Types shared by the data map fault and maintenance block
`default_nettype none
package dmf_pkg;

    // Bus channel state
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_RESP = 1'b1
    } dmf_bus_st_t;

    // Master to slave AXI4-Lite signals
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } dmf_axi_req_t;

    // Slave to master AXI4-Lite signals
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dmf_axi_rsp_t;

    // Fault or miss report from the load/store pipe
    typedef struct packed {
        logic valid;
        logic miss;
        logic write;
        logic access_viol_flag;
        logic pte_for;
        logic pte_fow;
        logic [4:0] ra;
        logic [5:0] opcode;
        logic [63:0] va;
    } dmf_fault_t;

endpackage
`default_nettype wire

// ### rtl/dmf_top.sv
// Data map buffer fault capture, maintenance commands and register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dmf_consts.svh"
module dmf_top #(
    parameter int unsigned SMALL_N = 32,
    parameter int unsigned LARGE_N = 4
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Register bus
    input wire dmf_pkg::dmf_axi_req_t axi_req_i,
    output var dmf_pkg::dmf_axi_rsp_t axi_rsp_o,
    // Fault and miss reports
    input wire dmf_pkg::dmf_fault_t fault_i,
    // Instruction cache maintenance pulses
    output logic ic_flush_all_o,
    output logic ic_flush_ng_o
);
    import dmf_pkg::*;

    localparam int unsigned SW = $clog2(SMALL_N);
    localparam int unsigned LW = $clog2(LARGE_N);

    // Bus channel state
    dmf_bus_st_t wst_q, wst_d, rst_q, rst_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_go, rd_go;

    // Software-written state
    logic size_q, size_d;
    logic [31:0] stage_q, stage_d, tag_q, tag_d;
    logic [SW-1:0] sptr_q, sptr_d;
    logic [LW-1:0] lptr_q, lptr_d;
    logic [63:0] hold_q, hold_d;

    // Capture state
    logic lock_q, lock_d;
    logic [14:0] fstat_q, fstat_d;
    logic [63:0] faddr_q, faddr_d;

    // Command pulses
    logic ic_all_q, ic_all_d, ic_ng_q, ic_ng_d;

    // Decoded write strobes and read side effects
    logic we_size, we_stage, we_tag, we_port, we_unlock;
    logic we_clr_all, we_clr_ng, we_clr_one, we_ic_all, we_ic_ng;
    logic we_bad, re_port, re_faddr;
    logic [7:0] wa, ra;
    logic [31:0] wd;
    logic [63:0] s_pte, l_pte, new_pte;

    // A write is taken only with address and data both offered
    assign wr_go = ce_i && wst_q == BUS_IDLE && axi_req_i.awvalid && axi_req_i.wvalid;
    assign rd_go = ce_i && rst_q == BUS_IDLE && axi_req_i.arvalid;
    assign wa = axi_req_i.awaddr;
    assign ra = axi_req_i.araddr;
    assign wd = axi_req_i.wdata;
    assign new_pte = {stage_q, wd};

    // Write address decode
    always_comb begin
        we_size = 1'b0;
        we_stage = 1'b0;
        we_tag = 1'b0;
        we_port = 1'b0;
        we_unlock = 1'b0;
        we_clr_all = 1'b0;
        we_clr_ng = 1'b0;
        we_clr_one = 1'b0;
        we_ic_all = 1'b0;
        we_ic_ng = 1'b0;
        we_bad = 1'b0;
        if (!wr_go) begin
            we_bad = 1'b0;
        end else if (wa == `DMF_OFF_SIZE_CTL) begin
            we_size = 1'b1;
        end else if (wa == `DMF_OFF_STAGE) begin
            we_stage = 1'b1;
        end else if (wa == `DMF_OFF_TAG) begin
            we_tag = 1'b1;
        end else if (wa == `DMF_OFF_PORT) begin
            we_port = 1'b1;
        end else if (wa == `DMF_OFF_UNLOCK) begin
            we_unlock = 1'b1; // R7
        end else if (wa == `DMF_OFF_CLR_ALL) begin
            we_clr_all = 1'b1; // R23
        end else if (wa == `DMF_OFF_CLR_NG) begin
            we_clr_ng = 1'b1; // R23
        end else if (wa == `DMF_OFF_CLR_ONE) begin
            we_clr_one = 1'b1;
        end else if (wa == `DMF_OFF_IC_ALL) begin
            we_ic_all = 1'b1; // R23
        end else if (wa == `DMF_OFF_IC_NG) begin
            we_ic_ng = 1'b1; // R23
        end else if (wa == `DMF_OFF_HOLD_LO || wa == `DMF_OFF_HOLD_HI ||
                     wa == `DMF_OFF_FSTAT || wa == `DMF_OFF_FADDR_LO ||
                     wa == `DMF_OFF_FADDR_HI || wa == `DMF_OFF_INFO) begin
            we_bad = 1'b0; // R1
        end else begin
            we_bad = 1'b1;
        end
    end

    // Read side effects live only on the accepting edge
    assign re_port = rd_go && ra == `DMF_OFF_PORT;
    assign re_faddr = rd_go && ra == `DMF_OFF_FADDR_LO;

    // Read data mux; write-only offsets read as zero
    always_comb begin
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rd_go) begin
            rdata_d = 32'h0;
            rresp_d = `DMF_RESP_OK;
            if (ra == `DMF_OFF_SIZE_CTL) begin
                rdata_d = {31'h0, size_q};
            end else if (ra == `DMF_OFF_STAGE) begin
                rdata_d = stage_q;
            end else if (ra == `DMF_OFF_TAG) begin
                rdata_d = tag_q;
            end else if (ra == `DMF_OFF_HOLD_LO) begin
                rdata_d = hold_q[31:0]; // R2
            end else if (ra == `DMF_OFF_HOLD_HI) begin
                rdata_d = hold_q[63:32]; // R2
            end else if (ra == `DMF_OFF_FSTAT) begin
                rdata_d = {17'h0, fstat_q}; // R12
            end else if (ra == `DMF_OFF_FADDR_LO) begin
                rdata_d = faddr_q[31:0];
            end else if (ra == `DMF_OFF_FADDR_HI) begin
                rdata_d = faddr_q[63:32];
            end else if (ra == `DMF_OFF_INFO) begin
                rdata_d = 32'h0;
                rdata_d[`DMF_INFO_LOCK] = lock_q;
                rdata_d[`DMF_INFO_SPTR +: SW] = sptr_q;
                rdata_d[`DMF_INFO_LPTR +: LW] = lptr_q;
            end else if (ra == `DMF_OFF_PORT || ra == `DMF_OFF_UNLOCK ||
                         ra == `DMF_OFF_CLR_ALL || ra == `DMF_OFF_CLR_NG ||
                         ra == `DMF_OFF_CLR_ONE || ra == `DMF_OFF_IC_ALL ||
                         ra == `DMF_OFF_IC_NG) begin
                rdata_d = 32'h0;
            end else begin
                rresp_d = `DMF_RESP_ERR;
            end
        end
    end

    // Channel states: one write and one read in flight at most
    always_comb begin
        wst_d = wst_q;
        rst_d = rst_q;
        bresp_d = bresp_q;
        if (wr_go) begin
            wst_d = BUS_RESP;
            bresp_d = we_bad ? `DMF_RESP_ERR : `DMF_RESP_OK;
        end else if (ce_i && wst_q == BUS_RESP && axi_req_i.bready) begin
            wst_d = BUS_IDLE;
        end
        if (rd_go) begin
            rst_d = BUS_RESP;
        end else if (ce_i && rst_q == BUS_RESP && axi_req_i.rready) begin
            rst_d = BUS_IDLE;
        end
    end

    // Entry storage, one array per page size
    dmf_map_array #(
        .N(SMALL_N),
        .IGN(0),
        .IW(SW)
    ) u_small (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .wr_i(we_port && !size_q), // R20
        .idx_i(sptr_q),
        .tag_i(tag_q),
        .pte_i(new_pte),
        .pte_o(s_pte),
        .inv_all_i(we_clr_all), // R14
        .inv_ng_i(we_clr_ng), // R16
        .inv_one_i(we_clr_one), // R17
        .va_tag_i(wd)
    );

    dmf_map_array #(
        .N(LARGE_N),
        .IGN(`DMF_LARGE_IGN),
        .IW(LW)
    ) u_large (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .wr_i(we_port && size_q), // R20
        .idx_i(lptr_q),
        .tag_i(tag_q),
        .pte_i(new_pte),
        .pte_o(l_pte),
        .inv_all_i(we_clr_all), // R14
        .inv_ng_i(we_clr_ng), // R16
        .inv_one_i(we_clr_one), // R17
        .va_tag_i(wd)
    );

    // Software registers, pointers and readback holder
    always_comb begin
        size_d = we_size ? wd[0] : size_q;
        stage_d = we_stage ? wd : stage_q;
        tag_d = we_tag ? wd : tag_q;
        sptr_d = sptr_q;
        lptr_d = lptr_q;
        hold_d = hold_q;
        // Port reads and writes step the pointer of the selected size
        if ((we_port || re_port) && !size_q) begin
            sptr_d = sptr_q + SW'(1); // R21
        end
        if ((we_port || re_port) && size_q) begin
            lptr_d = lptr_q + LW'(1); // R21
        end
        if (re_port) begin
            hold_d = size_q ? l_pte : s_pte; // R2
        end
        // Clear-all wins over a stepping read in the same cycle
        if (we_clr_all) begin
            sptr_d = '0; // R15
            lptr_d = '0; // R15
        end
        ic_all_d = we_ic_all; // R18
        ic_ng_d = we_ic_ng; // R19
    end

    // Fault capture; the lock only sets while clear, so a release never races a capture
    always_comb begin
        lock_d = lock_q;
        fstat_d = fstat_q;
        faddr_d = faddr_q;
        if (ce_i && fault_i.valid && !lock_q) begin // R5
            fstat_d = '0;
            fstat_d[`DMF_FS_WR] = fault_i.write; // R8
            fstat_d[`DMF_FS_ACV] = fault_i.access_viol_flag; // R9
            fstat_d[`DMF_FS_FOR] = !fault_i.write && fault_i.pte_for; // R10
            fstat_d[`DMF_FS_FOW] = fault_i.write && fault_i.pte_fow; // R11
            fstat_d[`DMF_FS_RA +: 5] = fault_i.ra; // R12
            fstat_d[`DMF_FS_OP +: 6] = fault_i.opcode; // R12
            faddr_d = fault_i.va; // R13
            lock_d = 1'b1; // R3 R4
        end else if (re_faddr || we_unlock) begin
            lock_d = 1'b0; // R22
        end
    end

    // State registers; enable low freezes everything
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wst_q <= BUS_IDLE;
            rst_q <= BUS_IDLE;
            bresp_q <= `DMF_RESP_OK;
            rresp_q <= `DMF_RESP_OK;
            rdata_q <= 32'h0;
            size_q <= 1'b0;
            stage_q <= 32'h0;
            tag_q <= 32'h0;
            sptr_q <= '0;
            lptr_q <= '0;
            hold_q <= 64'h0;
            lock_q <= 1'b0; // R6
            fstat_q <= '0;
            faddr_q <= 64'h0;
            ic_all_q <= 1'b0;
            ic_ng_q <= 1'b0;
        end else if (ce_i) begin
            wst_q <= wst_d;
            rst_q <= rst_d;
            bresp_q <= bresp_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            size_q <= size_d;
            stage_q <= stage_d;
            tag_q <= tag_d;
            sptr_q <= sptr_d;
            lptr_q <= lptr_d;
            hold_q <= hold_d;
            lock_q <= lock_d;
            fstat_q <= fstat_d;
            faddr_q <= faddr_d;
            ic_all_q <= ic_all_d;
            ic_ng_q <= ic_ng_d;
        end
    end

    // Bus outputs: readies are combinational, payloads from flops
    always_comb begin
        axi_rsp_o.awready = wr_go;
        axi_rsp_o.wready = wr_go;
        axi_rsp_o.bvalid = wst_q == BUS_RESP;
        axi_rsp_o.bresp = bresp_q;
        axi_rsp_o.arready = rd_go;
        axi_rsp_o.rvalid = rst_q == BUS_RESP;
        axi_rsp_o.rdata = rdata_q;
        axi_rsp_o.rresp = rresp_q;
    end

    assign ic_flush_all_o = ic_all_q;
    assign ic_flush_ng_o = ic_ng_q;
endmodule
`default_nettype wire

// ### testbench/dmf_top_properties.sv
// Port-level concurrent checks for the data map fault and maintenance block
`timescale 1ns/1ps
`default_nettype none
module dmf_top_properties (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Register bus and fault port
    input wire dmf_pkg::dmf_axi_req_t axi_req_i,
    input wire dmf_pkg::dmf_axi_rsp_t axi_rsp_o,
    input wire dmf_pkg::dmf_fault_t fault_i,
    // Flush pulses
    input wire logic ic_flush_all_o,
    input wire logic ic_flush_ng_o
);
    import dmf_pkg::*;
    logic wtk;
    logic rtk;
    logic wfa;
    logic wng;
    // Transfers taken; flush commands keyed on the taken write address
    assign wtk = axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
    assign rtk = axi_req_i.arvalid && axi_rsp_o.arready;
    assign wfa = wtk && (axi_req_i.awaddr == 8'h34);
    assign wng = wtk && (axi_req_i.awaddr == 8'h38);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_fa_go; wfa |=> ic_flush_all_o && !ic_flush_ng_o; endproperty
    a_fa_go: assert property (p_fa_go) else $error("flush all pulse missing");
    property p_fa_one; ic_flush_all_o |-> $past(wfa) ##1 !ic_flush_all_o; endproperty
    a_fa_one: assert property (p_fa_one) else $error("stray or long flush all");
    property p_ng_go; wng |=> ic_flush_ng_o && !ic_flush_all_o; endproperty
    a_ng_go: assert property (p_ng_go) else $error("non-global flush missing");
    property p_ng_one; ic_flush_ng_o |-> $past(wng) ##1 !ic_flush_ng_o; endproperty
    a_ng_one: assert property (p_ng_one) else $error("stray non-global flush");
    property p_wr_ans; wtk |=> axi_rsp_o.bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    // Read answer one cycle after it is taken, and no second read taken in that cycle
    property p_rd_hold;
        rtk |=> axi_rsp_o.rvalid && !axi_rsp_o.arready;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read answer late");
    property p_port_zero;
        rtk && axi_req_i.araddr == 8'h0C |=>
            axi_rsp_o.rvalid && axi_rsp_o.rdata == 32'h0 && axi_rsp_o.rresp == 2'h0;
    endproperty
    a_port_zero: assert property (p_port_zero) else $error("entry port read not zero");
    property p_ro_ok;
        wtk && axi_req_i.awaddr == 8'h10 |=> axi_rsp_o.bvalid && axi_rsp_o.bresp == 2'h0;
    endproperty
    a_ro_ok: assert property (p_ro_ok) else $error("holder write refused");
endmodule
bind dmf_top dmf_top_properties u_dmf_top_properties (.clk_i(clk_i), .srst_i(srst_i),
    .ce_i(ce_i), .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .fault_i(fault_i),
    .ic_flush_all_o(ic_flush_all_o), .ic_flush_ng_o(ic_flush_ng_o));
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the data map fault and maintenance block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dmf_pkg::*;
    logic clk_i;
    logic srst_i;
    logic ce_i;
    dmf_axi_req_t req;
    dmf_axi_rsp_t rsp;
    dmf_fault_t fault_q;
    logic ic_fa;
    logic ic_ng;
    int error_cnt;
    int checked;
    int n_fa;
    int n_ng;
    dmf_top #(.SMALL_N(32), .LARGE_N(4)) u_dmf_top (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .axi_req_i(req), .axi_rsp_o(rsp), .fault_i(fault_q), .ic_flush_all_o(ic_fa),
        .ic_flush_ng_o(ic_ng));
    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Count flush pulses at the falling edge, clear of the edge that launches them
    always @(negedge clk_i) begin
        if (ic_fa === 1'b1) n_fa++;
        if (ic_ng === 1'b1) n_ng++;
    end
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Ready is looked at on the falling edge, where it is settled for the next rise
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        @(posedge clk_i);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.bready <= 1'b1;
        do @(negedge clk_i); while (rsp.awready !== 1'b1);
        @(posedge clk_i);
        req.awvalid <= 1'b0;
        req.wvalid <= 1'b0;
        do @(negedge clk_i); while (rsp.bvalid !== 1'b1);
        chk(64'(rsp.bresp), 64'(er));
        @(posedge clk_i);
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        @(posedge clk_i);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do @(negedge clk_i); while (rsp.arready !== 1'b1);
        @(posedge clk_i);
        req.arvalid <= 1'b0;
        do @(negedge clk_i); while (rsp.rvalid !== 1'b1);
        chk(64'(rsp.rresp), 64'(er));
        if (er == 2'h0) chk(64'(rsp.rdata), 64'(e));
        @(posedge clk_i);
        req.rready <= 1'b0;
    endtask
    // One-cycle fault report; c gives the clock enable during it
    task automatic fl(input dmf_fault_t f, input logic c);
        @(posedge clk_i);
        fault_q <= f;
        ce_i <= c;
        @(posedge clk_i);
        fault_q.valid <= 1'b0;
        ce_i <= 1'b1;
    endtask
    task automatic t_reset;
        rd(8'h3C, 32'h0);
        rd(8'h18, 32'h0);
    endtask
    // Write fault, fault while locked, unlock by address read, read fault, unlock command
    task automatic t_fault;
        fl('{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 5'h1A, 6'h2B, 64'h0123_4567_89AB_CDE8}, 1'b1);
        rd(8'h18, 32'h57AB);
        rd(8'h3C, 32'h1);
        fl('{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 5'h03, 6'h11, 64'hFFFF_0000_0000_1000}, 1'b1);
        rd(8'h18, 32'h57AB);
        rd(8'h20, 32'h0123_4567);
        rd(8'h3C, 32'h1);
        rd(8'h1C, 32'h89AB_CDE8);
        rd(8'h3C, 32'h0);
        fl('{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 5'h03, 6'h11, 64'hFFFF_0000_0000_1000}, 1'b1);
        rd(8'h18, 32'h2234);
        wr(8'h18, 32'hFFFF_FFFF);
        rd(8'h18, 32'h2234);
        wr(8'h24, 32'h0);
        rd(8'h3C, 32'h0);
    endtask
    // A report with the enable low is dropped; a miss is captured like a fault
    task automatic t_miss;
        fl('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 6'h00, 64'h0000_0000_0000_2000}, 1'b0);
        rd(8'h3C, 32'h0);
        fl('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 6'h00, 64'h0000_0000_0000_2000}, 1'b1);
        rd(8'h3C, 32'h1);
        rd(8'h18, 32'h0);
        rd(8'h1C, 32'h2000);
        rd(8'h3C, 32'h0);
    endtask
    // Large array fill and wrap, readback through the holder, clear-all pointer return
    // Slot valid bits have no register, so invalidation is judged on the slots themselves
    task automatic t_entry;
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h0000_0ABC);
        wr(8'h08, 32'h0000_1234);
        for (int i = 0; i < 3; i++) wr(8'h0C, 32'hC0DE_0010 + 32'(i));
        rd(8'h3C, 32'h0003_0000);
        wr(8'h0C, 32'hC0DE_0013);
        rd(8'h3C, 32'h0);
        rd(8'h0C, 32'h0);
        rd(8'h10, 32'hC0DE_0010);
        rd(8'h14, 32'h0000_0ABC);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, 32'hC0DE_0010);
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h0000_0010);
        rd(8'h3C, 32'h0001_0100);
        chk(64'(u_dmf_top.u_large.g_ent[3].v_q), 64'h1);
        wr(8'h28, 32'hFFFF_FFFF);
        chk(64'(u_dmf_top.u_large.g_ent[3].v_q), 64'h0);
        chk(64'(u_dmf_top.u_small.g_ent[0].v_q), 64'h0);
        rd(8'h3C, 32'h0);
        wr(8'h0C, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0010);
        wr(8'h08, 32'h0000_5678);
        wr(8'h0C, 32'h0000_0010);
        wr(8'h2C, 32'h5A5A_5A5A);
        chk(64'(u_dmf_top.u_small.g_ent[0].v_q), 64'h0);
        chk(64'(u_dmf_top.u_small.g_ent[1].v_q), 64'h1);
        wr(8'h30, 32'h0000_1234);
        chk(64'(u_dmf_top.u_small.g_ent[1].v_q), 64'h0);
        chk(64'(u_dmf_top.u_small.g_ent[2].v_q), 64'h1);
    endtask
    task automatic t_flush;
        wr(8'h34, 32'h0);
        wr(8'h38, 32'hFFFF_FFFF);
        wr(8'h34, 32'h1234_5678);
        chk(64'(n_fa), 64'h2);
        chk(64'(n_ng), 64'h1);
    endtask
    task automatic t_bad;
        wr(8'h40, 32'h0, 2'h2);
        rd(8'hFC, 32'h0, 2'h2);
    endtask
    task automatic summarize;
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        srst_i = 1'b1;
        ce_i = 1'b1;
        req = '0;
        fault_q = '0;
        error_cnt = 0;
        checked = 0;
        n_fa = 0;
        n_ng = 0;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_fault();
        t_miss();
        t_entry();
        t_flush();
        t_bad();
        summarize();
    end
    // Whole run needs under two hundred cycles; this cuts a hang short
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
